/* File: src/frx_defines.vh */
`ifndef FRX_DEFINES_VH
`define FRX_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FRX_OFS_CTRL 8'h00
`define FRX_OFS_GAIN 8'h04
`define FRX_OFS_AGC 8'h08
`define FRX_OFS_CLKDIV 8'h0C
`define FRX_OFS_CALDIV 8'h10
`define FRX_OFS_DEMOD 8'h14
`define FRX_OFS_STATUS 8'h18

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define FRX_CTRL_TXRX 0
`define FRX_CTRL_AMPMODE 1
`define FRX_CTRL_MIXLIN 2
`define FRX_CTRL_LPFBW_LO 3
`define FRX_CTRL_CALGO 5
`define FRX_CTRL_OFSDIV_LO 6
`define FRX_CTRL_DEMSEL_LO 8
`define FRX_CTRL_AUTO_LO 10

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FRX_RST_CTRL 12'h001
`define FRX_RST_GAIN 4'hB
`define FRX_RST_AGC_LOW 7'h1E
`define FRX_RST_AGC_HIGH 7'h46
`define FRX_RST_GAIN_LOOP_DELAY_COUNT 8'h0A
`define FRX_RST_SEQDIV 8'h14
`define FRX_RST_CDRDIV 16'h0028
`define FRX_RST_CALDIV 9'h0C8
`define FRX_RST_POSTBW 10'h057
`define FRX_RST_CORRBW 10'h009

// ----------------------------------------
// Codes and timing
// ----------------------------------------
`define FRX_DEM_LINEAR 2'h0
`define FRX_DEM_CORR 2'h1
`define FRX_AGC_STEPS 3'h5
`define FRX_CLK_MHZ 250
`define FRX_CAL_TIME_US 200
`define FRX_FLASH_LEVELS 80

`endif

/* File: src/frx_demod.v */
`timescale 1ns/1ps
`include "frx_defines.vh"

module frx_demod (
  aclk,
  aresetn,
  ce,
  i_sign,
  q_sign,
  demod_sel,
  corr_bw,
  post_bw,
  sliced
);
  input wire aclk;
  input wire aresetn;
  input wire ce;
  input wire i_sign;
  input wire q_sign;
  input wire [1:0] demod_sel;
  input wire [9:0] corr_bw;
  input wire [9:0] post_bw;
  output reg sliced;

  reg [1:0] quad_q;
  reg [9:0] win_q;
  reg [9:0] pos_q;
  reg [9:0] neg_q;
  reg signed [11:0] disc_q;
  reg signed [11:0] y1_q;
  reg signed [11:0] y2_q;
  wire [1:0] quad;
  wire [1:0] step;
  wire rot_pos;
  wire rot_neg;
  wire [9:0] pos_n;
  wire [9:0] neg_n;
  wire signed [11:0] x;
  wire signed [24:0] m1;
  wire signed [24:0] m2;

  // ----------------------------------------
  // Limited I/Q quadrant and rotation sense
  // ----------------------------------------
  // Sign pair is Gray coded around the circle
  assign quad = {q_sign, i_sign ^ q_sign};
  assign step = quad - quad_q;
  assign rot_pos = (step == 2'h1);
  assign rot_neg = (step == 2'h3);
  // Window closing sample still counts
  assign pos_n = pos_q + {9'h000, rot_pos};
  assign neg_n = neg_q + {9'h000, rot_neg};

  // Linear path takes the raw rotation, correlator path the held decision
  assign x = (demod_sel == `FRX_DEM_CORR) ? disc_q :
             (rot_pos ? 12'sh1FF : (rot_neg ? -12'sh1FF : 12'sh000));
  assign m1 = (x - y1_q) * $signed({1'b0, post_bw});
  assign m2 = (y1_q - y2_q) * $signed({1'b0, post_bw});

  always @(posedge aclk) begin
    if (!aresetn) begin
      quad_q <= 2'h0;
      win_q <= 10'h000;
      pos_q <= 10'h000;
      neg_q <= 10'h000;
      disc_q <= 12'sh000;
      y1_q <= 12'sh000;
      y2_q <= 12'sh000;
      sliced <= 1'b0;
    end else if (ce) begin
      quad_q <= quad;
      // Two correlators over a quarter period of the deviation
      if (win_q + 10'h001 >= corr_bw) begin
        win_q <= 10'h000;
        pos_q <= 10'h000;
        neg_q <= 10'h000;
        if (pos_n > neg_n) begin
          disc_q <= 12'sh1FF;
        end else if (neg_n > pos_n) begin
          disc_q <= -12'sh1FF;
        end
      end else begin
        win_q <= win_q + 10'h001;
        pos_q <= pos_n;
        neg_q <= neg_n;
      end
      // Second-order smoothing, two cascaded poles
      y1_q <= y1_q + m1[21:10];
      y2_q <= y2_q + m2[21:10];
      sliced <= (y2_q > 12'sh000);
    end
  end
endmodule // frx_demod

/* File: src/frx_top.v */
`timescale 1ns/1ps
`include "frx_defines.vh"

module frx_top #(
  parameter CAL_CYCLES = `FRX_CAL_TIME_US * `FRX_CLK_MHZ,
  parameter FLASH_LEVELS = `FRX_FLASH_LEVELS
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [FLASH_LEVELS-1:0] flash_therm,
  input wire bb_i_sign,
  input wire bb_q_sign,
  output reg rx_input_short_switch,
  output reg front_amp_power_mode,
  output reg mixer_linear_mode,
  output reg [1:0] lpf_bw_sel,
  output reg [8:0] lpf_cal_divider,
  output reg lpf_cal_busy,
  output reg [1:0] front_amp_gain_level,
  output reg [1:0] filter_gain_level,
  output reg offset_correction_clock,
  output reg rx_data,
  output reg rx_clk
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [11:0] ctrl_q;
  reg [3:0] gain_q;
  reg [6:0] agc_low_q;
  reg [6:0] agc_high_q;
  reg [7:0] gain_loop_delay_count_q;
  reg [7:0] sequencer_clock_divider_q;
  reg [15:0] cdr_div_q;
  reg [9:0] post_bw_q;
  reg [9:0] correlator_bandwidth_setting_q;
  reg [7:0] awaddr_q;
  reg aw_full_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_full_q;
  reg [6:0] strength_code_q;
  reg [2:0] agc_idx_q;
  reg agc_wait_q;
  reg [15:0] agc_cnt_q;
  reg [15:0] cal_cnt_q;
  reg [3:0] ofs_cnt_q;
  reg [1:0] ofs_sel_q;
  reg [15:0] cdr_cnt_q;
  reg [4:0] phase_q;
  reg prev_bit_q;
  reg [FLASH_LEVELS-1:0] therm_m_q;
  reg [FLASH_LEVELS-1:0] therm_q;
  reg [1:0] iq_m_q;
  reg [1:0] iq_q;
  reg [31:0] rd_d;
  reg [6:0] ones_d;
  reg [1:0] amp_d;
  reg [1:0] fgain_d;
  reg ofs_d;
  wire agc_on;
  wire wr_go;
  wire cal_go;
  wire sliced;
  wire cdr_tick;
  wire [15:0] wait_len;
  integer k;

  assign agc_on = &ctrl_q[`FRX_CTRL_AUTO_LO +: 2];
  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;
  assign cal_go = wr_go && (awaddr_q == `FRX_OFS_CTRL) && wstrb_q[0] && wdata_q[`FRX_CTRL_CALGO];
  assign wait_len = gain_loop_delay_count_q * sequencer_clock_divider_q;
  assign cdr_tick = (cdr_cnt_q + 16'h0001 >= cdr_div_q);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      therm_m_q <= {FLASH_LEVELS{1'b0}};
      therm_q <= {FLASH_LEVELS{1'b0}};
      iq_m_q <= 2'h0;
      iq_q <= 2'h0;
    end else if (ce) begin
      therm_m_q <= flash_therm;
      therm_q <= therm_m_q;
      iq_m_q <= {bb_i_sign, bb_q_sign};
      iq_q <= iq_m_q;
    end
  end

  // ----------------------------------------
  // Flash code and gain mapping
  // ----------------------------------------
  always @* begin
    ones_d = 7'h00;
    for (k = 0; k < FLASH_LEVELS; k = k + 1) begin
      ones_d = ones_d + {6'h00, therm_q[k]};
    end
    // Ladder of six gain states, five changes
    case (agc_idx_q)
      3'h0: begin
        amp_d = 2'h3;
        fgain_d = 2'h2;
      end
      3'h1: begin
        amp_d = 2'h2;
        fgain_d = 2'h2;
      end
      3'h2: begin
        amp_d = 2'h2;
        fgain_d = 2'h1;
      end
      3'h3: begin
        amp_d = 2'h2;
        fgain_d = 2'h0;
      end
      3'h4: begin
        amp_d = 2'h1;
        fgain_d = 2'h0;
      end
      default: begin
        amp_d = 2'h0;
        fgain_d = 2'h0;
      end
    endcase
    if (!agc_on) begin
      amp_d = gain_q[1:0];
      fgain_d = (gain_q[3:2] == 2'h3) ? 2'h2 : gain_q[3:2];
    end
    case (ofs_sel_q)
      2'h0: ofs_d = ofs_cnt_q[1];
      2'h1: ofs_d = ofs_cnt_q[2];
      default: ofs_d = ofs_cnt_q[3];
    endcase
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @* begin
    rd_d = 32'h0000_0000;
    case (s_axi_araddr)
      `FRX_OFS_CTRL: rd_d = {20'h00000, ctrl_q};
      `FRX_OFS_GAIN: rd_d = {28'h0000000, gain_q};
      `FRX_OFS_AGC: rd_d = {10'h000, gain_loop_delay_count_q, agc_high_q, agc_low_q};
      `FRX_OFS_CLKDIV: rd_d = {8'h00, cdr_div_q, sequencer_clock_divider_q};
      `FRX_OFS_CALDIV: rd_d = {23'h000000, lpf_cal_divider};
      `FRX_OFS_DEMOD: rd_d = {12'h000, correlator_bandwidth_setting_q, post_bw_q};
      `FRX_OFS_STATUS: rd_d = {18'h00000, rx_data, lpf_cal_busy, filter_gain_level,
                               front_amp_gain_level, strength_code_q, 1'b0};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      awaddr_q <= 8'h00;
      aw_full_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_full_q <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= !aw_full_q && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_full_q && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q > `FRX_OFS_DEMOD || awaddr_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= (s_axi_araddr > `FRX_OFS_STATUS || s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `FRX_RST_CTRL;
      gain_q <= `FRX_RST_GAIN;
      agc_low_q <= `FRX_RST_AGC_LOW;
      agc_high_q <= `FRX_RST_AGC_HIGH;
      gain_loop_delay_count_q <= `FRX_RST_GAIN_LOOP_DELAY_COUNT;
      sequencer_clock_divider_q <= `FRX_RST_SEQDIV;
      cdr_div_q <= `FRX_RST_CDRDIV;
      lpf_cal_divider <= `FRX_RST_CALDIV;
      post_bw_q <= `FRX_RST_POSTBW;
      correlator_bandwidth_setting_q <= `FRX_RST_CORRBW;
    end else if (ce) begin
      if (wr_go && wstrb_q == 4'hF) begin
        case (awaddr_q)
          `FRX_OFS_CTRL: ctrl_q <= wdata_q[11:0] & 12'hFDF;
          `FRX_OFS_GAIN: gain_q <= wdata_q[3:0];
          `FRX_OFS_AGC: begin
            agc_low_q <= wdata_q[6:0];
            agc_high_q <= wdata_q[13:7];
            gain_loop_delay_count_q <= wdata_q[21:14];
          end
          `FRX_OFS_CLKDIV: begin
            sequencer_clock_divider_q <= wdata_q[7:0];
            cdr_div_q <= wdata_q[23:8];
          end
          `FRX_OFS_CALDIV: lpf_cal_divider <= wdata_q[8:0];
          `FRX_OFS_DEMOD: begin
            post_bw_q <= wdata_q[9:0];
            correlator_bandwidth_setting_q <= wdata_q[19:10];
          end
          default: ctrl_q <= ctrl_q;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Front end, calibration, offset clock
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_input_short_switch <= 1'b0;
      front_amp_power_mode <= 1'b0;
      mixer_linear_mode <= 1'b0;
      lpf_bw_sel <= 2'h0;
      lpf_cal_busy <= 1'b0;
      cal_cnt_q <= 16'h0000;
      ofs_cnt_q <= 4'h0;
      ofs_sel_q <= 2'h0;
      offset_correction_clock <= 1'b0;
    end else if (ce) begin
      rx_input_short_switch <= !ctrl_q[`FRX_CTRL_TXRX];
      front_amp_power_mode <= ctrl_q[`FRX_CTRL_AMPMODE];
      mixer_linear_mode <= ctrl_q[`FRX_CTRL_MIXLIN];
      lpf_bw_sel <= ctrl_q[`FRX_CTRL_LPFBW_LO +: 2];
      if (cal_go && !lpf_cal_busy) begin
        lpf_cal_busy <= 1'b1;
        cal_cnt_q <= CAL_CYCLES[15:0] - 16'h0001;
      end else if (lpf_cal_busy) begin
        if (cal_cnt_q == 16'h0000) begin
          lpf_cal_busy <= 1'b0;
        end else begin
          cal_cnt_q <= cal_cnt_q - 16'h0001;
        end
      end
      ofs_cnt_q <= ofs_cnt_q + 4'h1;
      // Divider change only at counter wrap, no short half period
      if (ofs_cnt_q == 4'hF) begin
        ofs_sel_q <= ctrl_q[`FRX_CTRL_OFSDIV_LO +: 2];
      end
      offset_correction_clock <= ofs_d;
    end
  end

  // ----------------------------------------
  // Gain loop
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      strength_code_q <= 7'h00;
      agc_idx_q <= 3'h0;
      agc_wait_q <= 1'b0;
      agc_cnt_q <= 16'h0000;
      front_amp_gain_level <= 2'h3;
      filter_gain_level <= 2'h2;
    end else if (ce) begin
      strength_code_q <= ones_d;
      front_amp_gain_level <= amp_d;
      filter_gain_level <= fgain_d;
      if (!agc_on) begin
        agc_idx_q <= 3'h0;
        agc_wait_q <= 1'b0;
      end else if (agc_wait_q) begin
        agc_cnt_q <= agc_cnt_q - 16'h0001;
        if (agc_cnt_q <= 16'h0001) begin
          agc_wait_q <= 1'b0;
        end
      end else if (strength_code_q > agc_high_q && agc_idx_q < `FRX_AGC_STEPS) begin
        agc_idx_q <= agc_idx_q + 3'h1;
        agc_wait_q <= 1'b1;
        agc_cnt_q <= wait_len;
      end else if (strength_code_q < agc_low_q && agc_idx_q != 3'h0) begin
        agc_idx_q <= agc_idx_q - 3'h1;
        agc_wait_q <= 1'b1;
        agc_cnt_q <= wait_len;
      end
    end
  end

  // ----------------------------------------
  // Demodulator
  // ----------------------------------------
  frx_demod u_demod (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .i_sign(iq_q[1]),
    .q_sign(iq_q[0]),
    .demod_sel(ctrl_q[`FRX_CTRL_DEMSEL_LO +: 2]),
    .corr_bw(correlator_bandwidth_setting_q),
    .post_bw(post_bw_q),
    .sliced(sliced)
  );

  // ----------------------------------------
  // Bit recovery loop
  // ----------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      cdr_cnt_q <= 16'h0000;
      phase_q <= 5'h00;
      prev_bit_q <= 1'b0;
      rx_data <= 1'b0;
      rx_clk <= 1'b0;
    end else if (ce) begin
      cdr_cnt_q <= cdr_tick ? 16'h0000 : cdr_cnt_q + 16'h0001;
      if (cdr_tick) begin
        prev_bit_q <= sliced;
        // Nudge phase one step toward the data edge
        if (sliced != prev_bit_q && phase_q != 5'h00) begin
          phase_q <= phase_q[4] ? phase_q + 5'h02 : phase_q;
        end else begin
          phase_q <= phase_q + 5'h01;
        end
        if (phase_q == 5'h10) begin
          rx_data <= sliced;
        end
        rx_clk <= phase_q[4];
      end
    end
  end
endmodule // frx_top

/* File: bench/frx_fsk_tx.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Remote FSK sender seen as limited I/Q signs
// ----------------------------------------
module frx_fsk_tx #(
  parameter int STEP = 4
) (
  input wire logic aclk,
  input wire logic active,
  input wire logic tx_bit,
  output logic i_sign,
  output logic q_sign
);
  logic [1:0] ph_q = 2'h0;
  int n_q = 0;
  initial begin
    i_sign = 1'b0;
    q_sign = 1'b1;
  end
  always @(posedge aclk) begin
    if (!active) begin
      // No carrier: limiter outputs chatter
      i_sign <= ~i_sign;
      q_sign <= i_sign;
    end else begin
      n_q <= (n_q == STEP - 1) ? 0 : n_q + 1;
      // Rotation sense gives plus or minus deviation
      if (n_q == STEP - 1) ph_q <= tx_bit ? ph_q + 2'h1 : ph_q - 2'h1;
      i_sign <= ph_q[1];
      q_sign <= ph_q[1] ^ ph_q[0];
    end
  end
endmodule  // frx_fsk_tx

/* File: bench/frx_top_asserts.sv */
`timescale 1ns/1ps
module frx_top_asserts #(
  parameter CAL_CYCLES = 20
) (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire rx_input_short_switch,
  input wire [1:0] front_amp_gain_level,
  input wire [1:0] filter_gain_level,
  input wire lpf_cal_busy,
  input wire offset_correction_clock
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Calibration length counter
  // ----------------------------------------
  logic [31:0] busy_n_q;
  always @(posedge aclk) begin
    if (!aresetn) busy_n_q <= 32'h0;
    else if (ce) busy_n_q <= lpf_cal_busy ? busy_n_q + 32'h1 : 32'h0;
  end
  sequence aw_take_s;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence w_take_s;
    s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  reset_state_a: assert property ($rose(aresetn) |-> !rx_input_short_switch && !lpf_cal_busy &&
    front_amp_gain_level == 2'h3 && filter_gain_level == 2'h2) else $error("reset state wrong");
  cal_length_a: assert property ($fell(lpf_cal_busy) |-> busy_n_q == CAL_CYCLES)
    else $error("calibration length wrong");
  offset_clk_a: assert property ($changed(offset_correction_clock) |=>
    $stable(offset_correction_clock) ##1 (##[0:6] $changed(offset_correction_clock)))
    else $error("offset clock half period wrong");
  write_answer_a: assert property ((aw_take_s and w_take_s) |-> ##2 s_axi_bvalid) else $error("no write response");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  read_answer_a: assert property (ar_take_s |=> s_axi_rvalid) else $error("no read data");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
endmodule  // frx_top_asserts

bind frx_top frx_top_asserts #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.aclk(aclk), .aresetn(aresetn), .ce(ce),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .rx_input_short_switch(rx_input_short_switch), .front_amp_gain_level(front_amp_gain_level),
  .filter_gain_level(filter_gain_level), .lpf_cal_busy(lpf_cal_busy),
  .offset_correction_clock(offset_correction_clock));

/* File: bench/tb_frx_top.sv */
`timescale 1ns/1ps
module tb_frx_top;
  localparam int CALN = 20;
  localparam int STEP = 4;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'hF;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [79:0] fl = 80'h0;
  logic act = 1'b0, txb = 1'b0, cap = 1'b0, pclk = 1'b0;
  wire awr, wrd, bv, arr, rv, ii, qq, sw, pm, ml, busy, oc, rxd, rxc;
  wire [1:0] bp, rp, bws, ag, fg;
  wire [31:0] rdat;
  wire [8:0] cdv;
  int err_total = 0, n_tests = 0;
  logic [1:0] bq[$];
  logic [65:0] rq[$];
  logic rxq[$];
  logic txa[48];
  logic [3:0] lad[6] = '{4'hE, 4'hA, 4'h9, 4'h8, 4'h4, 4'h0};
  always #2 aclk = ~aclk;
  frx_top #(.CAL_CYCLES(CALN)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(bp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .flash_therm(fl), .bb_i_sign(ii), .bb_q_sign(qq), .rx_input_short_switch(sw),
    .front_amp_power_mode(pm), .mixer_linear_mode(ml), .lpf_bw_sel(bws), .lpf_cal_divider(cdv),
    .lpf_cal_busy(busy), .front_amp_gain_level(ag), .filter_gain_level(fg),
    .offset_correction_clock(oc), .rx_data(rxd), .rx_clk(rxc));
  frx_fsk_tx #(.STEP(STEP)) peer (.aclk(aclk), .active(act), .tx_bit(txb), .i_sign(ii), .q_sign(qq));
  // ----------------------------------------
  // Helpers and bus tasks
  // ----------------------------------------
  task automatic complete_run();
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
    int n;
    n = 0;
    bq.push_back(e);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 300);
    br <= 1'b0;
    chk(n < 300, 1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF,
                    input logic [1:0] r = 2'h0);
    int n;
    n = 0;
    rq.push_back({m, r, e});
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 300);
    rr <= 1'b0;
    chk(n < 300, 1);
  endtask
  // Response checker and recovered bit capture
  always @(posedge aclk) begin
    logic [65:0] x;
    if (bv && br) chk(bp, bq.pop_front());
    if (rv && rr) begin
      x = rq.pop_front();
      chk(rp, x[33:32]);
      chk(rdat & x[65:34], x[31:0]);
    end
    if (cap && rxc && !pclk) rxq.push_back(rxd);
    pclk <= rxc;
  end
  // Whole run is about 13k cycles
  initial begin
    #200000;
    $display("mismatch t=%0t watchdog", $time);
    err_total++;
    complete_run();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int k, g, p, o, gap, ok;
    logic [3:0] prv;
    logic [1:0] f;
    void'($urandom(32'hAD34));
    cyc(6);
    aresetn <= 1'b1;
    chk({sw, ag, fg}, 5'h0E);
    rd(8'h00, 32'h1);
    rd(8'h04, 32'hB);
    rd(8'h08, 32'h0002_A31E);
    rd(8'h0C, 32'h0000_2814);
    rd(8'h10, 32'h0000_00C8);
    rd(8'h14, 32'h0000_2457);
    rd(8'h18, 32'h0000_0B00, 32'h0000_1F00);
    rd(8'h1C, 32'h0, 32'hFFFF_FFFF, 2'h2);
    rd(8'h06, 32'h0, 32'hFFFF_FFFF, 2'h2);
    wr(8'h20, 32'h1, 2'h2);
    wr(8'h18, 32'hFFFF_FFFF, 2'h2);
    repeat (6) begin
      k = $urandom_range(7, 0) | ($urandom_range(2, 0) << 3);
      wr(8'h00, k);
      cyc(2);
      chk({sw, pm, ml, bws}, {~k[0], k[1], k[2], k[4:3]});
    end
    for (g = 0; g < 16; g++) begin
      f = (g[3:2] == 2'h3) ? 2'h2 : g[3:2];
      wr(8'h04, g);
      cyc(2);
      chk({ag, fg}, {g[1:0], f});
      rd(8'h18, {20'h0, f, g[1:0], 8'h0}, 32'h0000_0F00);
    end
    for (g = 0; g < 5; g++) begin
      k = (g == 0) ? 0 : (g == 1) ? 80 : $urandom_range(79, 1);
      fl <= (80'h1 << k) - 80'h1;
      cyc(5);
      rd(8'h18, k << 1, 32'h0000_00FE);
    end
    k = $urandom_range(511, 0);
    wr(8'h10, k);
    cyc(1);
    chk(cdv, k[8:0]);
    wr(8'h00, 32'h21);
    chk(busy, 1'b1);
    g = 0;
    while (busy !== 1'b0 && g < 100) begin
      cyc(1);
      g++;
    end
    chk(g, CALN);
    rd(8'h00, 32'h0, 32'h0000_0020);
    for (g = 0; g < 3; g++) begin
      wr(8'h00, 32'h1 | (g << 6));
      cyc(20);
      p = oc;
      k = 0;
      repeat (64) begin
        @(posedge aclk);
        if (oc && !p) k++;
        p = oc;
      end
      chk(k, 16 >> g);
    end
    wr(8'h08, 32'h0000_A31E);
    wr(8'h0C, 32'h0000_0403);
    fl <= (80'h1 << 79) - 80'h1;
    wr(8'h00, 32'h0401);
    cyc(20);
    chk({ag, fg}, 4'hE);
    fl <= (80'h1 << 50) - 80'h1;
    wr(8'h00, 32'h0C01);
    cyc(10);
    for (p = 0; p < 2; p++) begin
      k = p ? $urandom_range(29, 0) : $urandom_range(80, 71);
      fl <= (80'h1 << k) - 80'h1;
      for (g = 1; g < 6; g++) begin
        prv = {ag, fg};
        gap = 0;
        while ({ag, fg} === prv && gap < 60) begin
          cyc(1);
          gap++;
        end
        chk({ag, fg}, lad[p ? 5 - g : g]);
        if (g > 1) chk(gap >= 6, 1);
      end
      cyc(60);
      chk({ag, fg}, lad[p ? 0 : 5]);
    end
    wr(8'h14, 32'h26 | (STEP << 10));
    for (p = 0; p < 2; p++) begin
      wr(8'h00, p ? 32'h001 : 32'h101);
      act <= 1'b1;
      cap <= 1'b1;
      rxq.delete();
      for (g = 0; g < 48; g++) begin
        txa[g] = $urandom_range(1, 0);
        txb <= txa[g];
        cyc(128);
      end
      cap <= 1'b0;
      act <= 1'b0;
      ok = 0;
      for (o = 0; o < 5; o++) begin
        for (k = 0; k < 2; k++) begin
          gap = 0;
          for (g = 0; g < 24; g++)
            if (rxq.size() > g && rxq[rxq.size() - 1 - g] !== (txa[47 - g - o] ^ k[0])) gap = 1;
          if (gap == 0 && rxq.size() >= 24) ok = 1;
        end
      end
      chk(ok, 1);
    end
    complete_run();
  end
endmodule  // tb_frx_top
